// *** src/trap_ret_pkg.sv ***
package trap_ret_pkg;

  // Opcodes seen by the sequencer
  localparam logic [7:0] OP_SOFT_TRAP = 8'hFF;
  localparam logic [7:0] OP_RET_MASKABLE = 8'h2A;
  localparam logic [7:0] OP_RET_NONMASKABLE = 8'h3A;

  // Byte returned by a fetch with no memory behind it
  localparam logic [7:0] NO_MEMORY_BYTE = 8'hFF;

  // Address map defaults
  localparam logic [15:0] SFR_LO = 16'h0000;
  localparam logic [15:0] SFR_HI = 16'h003F;
  localparam logic [15:0] RAM_LO = 16'h0040;
  localparam logic [15:0] RAM_HI = 16'h013F;
  localparam logic [15:0] ROM_LO = 16'hE000;
  localparam logic [15:0] ROM_HI = 16'hFFFF;

  // Vector of the software trap, and stack pointer after reset
  localparam logic [15:0] SOFT_TRAP_VECTOR = 16'hFFE0;
  localparam logic [15:0] SP_RESET = 16'h013F;

  // Stack bytes moved per interrupt frame
  localparam logic [15:0] FRAME_BYTES = 16'h0003;

  // Position of the master enable inside the stacked status byte
  localparam int MIE_BIT = 7;

  localparam logic [7:0] PSW_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;

  typedef enum logic [7:0] {
    ST_IDLE = 8'b0000_0001,
    ST_PUSH_PSW = 8'b0000_0010,
    ST_PUSH_PCH = 8'b0000_0100,
    ST_PUSH_PCL = 8'b0000_1000,
    ST_POP_A = 8'b0001_0000,
    ST_POP_B = 8'b0010_0000,
    ST_POP_C = 8'b0100_0000,
    ST_POP_D = 8'b1000_0000
  } seq_state_t;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [7:0] rom_byte;
  } fetch_t;

  typedef struct packed {
    seq_state_t st;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [15:0] ret_pc;
    logic [15:0] vector;
    logic [7:0] program_status_word;
    logic [7:0] pcl;
    logic mie;
    logic pc_load;
    logic op_valid;
    logic [7:0] op_byte;
    logic trap_reset;
    logic addr_error;
    logic soft_int;
    logic busy;
  } core_state_t;

endpackage

// *** src/stack_ram.sv ***
`timescale 1ns/10ps
`default_nettype none
module stack_ram #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  // Read port, data one cycle later
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data_q
);

  if (AW < 1 || AW > 16 || DW < 1) begin : g_bad
    $error("stack_ram: unsupported geometry");
  end

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // No reset on the array or on the read data register
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_q <= mem[rd_addr];
  end

endmodule
`default_nettype wire

// *** src/trap_ret_unit.sv ***
`timescale 1ns/10ps
`default_nettype none
module trap_ret_unit #(
  parameter logic [15:0] RAM_LO = trap_ret_pkg::RAM_LO,
  parameter logic [15:0] RAM_HI = trap_ret_pkg::RAM_HI,
  parameter logic [15:0] ROM_LO = trap_ret_pkg::ROM_LO,
  parameter logic [15:0] ROM_HI = trap_ret_pkg::ROM_HI,
  parameter int STACK_AW = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Instruction fetch from the core
  input wire trap_ret_pkg::fetch_t fetch,
  // Core context
  input wire logic [15:0] cur_pc,
  input wire logic [7:0] cur_psw,
  input wire logic instr_last,
  input wire logic mie_set,
  input wire logic mie_clr,
  // Interrupt request already arbitrated outside
  input wire logic int_req,
  input wire logic [15:0] int_vector,
  // Opcode delivery
  output logic op_valid_q,
  output logic [7:0] op_byte_q,
  // Program counter redirect
  output logic pc_load_q,
  output logic [15:0] pc_q,
  // Context state
  output logic [15:0] sp_q,
  output logic [7:0] psw_q,
  output logic master_int_enable_q,
  output logic busy_q,
  // Events
  output logic soft_interrupt_q,
  output logic addr_error_q,
  output logic addr_trap_reset_q
);

  if (STACK_AW < 1 || STACK_AW > 16 || RAM_LO > RAM_HI || ROM_LO > ROM_HI) begin : g_bad
    $error("trap_ret_unit: bad address map or stack width");
  end

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [STACK_AW-1:0] stk(input logic [15:0] a);
    stk = a[STACK_AW-1:0];
  endfunction

  trap_ret_pkg::core_state_t s_q, s_d;
  logic wr_en;
  logic [STACK_AW-1:0] wr_addr;
  logic [7:0] wr_data;
  logic [STACK_AW-1:0] rd_addr;
  logic [7:0] rd_data;

  stack_ram #(
    .AW(STACK_AW),
    .DW(8)
  ) u_stack (
    .clk(mclk),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .rd_data_q(rd_data)
  );

  always_comb begin
    logic [7:0] byte_in;
    logic no_exec;
    byte_in = trap_ret_pkg::NO_MEMORY_BYTE;
    no_exec = 1'b0;
    s_d = s_q;
    s_d.pc_load = 1'b0;
    s_d.op_valid = 1'b0;
    s_d.trap_reset = 1'b0;
    s_d.addr_error = 1'b0;
    s_d.soft_int = 1'b0;
    wr_en = 1'b0;
    wr_addr = stk(s_q.sp);
    wr_data = 8'h00;
    rd_addr = stk(s_q.sp);
    case (s_q.st)
      trap_ret_pkg::ST_IDLE: begin
        if (mie_set) begin
          s_d.mie = 1'b1;
        end
        if (mie_clr) begin
          s_d.mie = 1'b0;
        end
        if (fetch.valid) begin
          no_exec = in_range(fetch.addr, trap_ret_pkg::SFR_LO, trap_ret_pkg::SFR_HI) ||
                    in_range(fetch.addr, RAM_LO, RAM_HI);
          if (in_range(fetch.addr, ROM_LO, ROM_HI)) begin
            byte_in = fetch.rom_byte;
          end else begin
            byte_in = trap_ret_pkg::NO_MEMORY_BYTE;
          end
        end
        if (fetch.valid && no_exec) begin
          // Reset request replaces the opcode entirely
          s_d.trap_reset = 1'b1;
        end else if (fetch.valid) begin
          s_d.op_valid = 1'b1;
          s_d.op_byte = byte_in;
          if (byte_in == trap_ret_pkg::OP_SOFT_TRAP) begin
            // Taken regardless of master enable or any pending request
            s_d.soft_int = 1'b1;
            s_d.addr_error = 1'b1;
            s_d.ret_pc = cur_pc;
            s_d.vector = trap_ret_pkg::SOFT_TRAP_VECTOR;
            s_d.busy = 1'b1;
            s_d.st = trap_ret_pkg::ST_PUSH_PSW;
          end else if (byte_in == trap_ret_pkg::OP_RET_MASKABLE ||
                       byte_in == trap_ret_pkg::OP_RET_NONMASKABLE) begin
            s_d.busy = 1'b1;
            s_d.st = trap_ret_pkg::ST_POP_A;
          end
        end else if (instr_last && int_req && s_q.mie) begin
          s_d.ret_pc = cur_pc;
          s_d.vector = int_vector;
          s_d.busy = 1'b1;
          s_d.st = trap_ret_pkg::ST_PUSH_PSW;
        end
        if (s_d.st == trap_ret_pkg::ST_PUSH_PSW) begin
          s_d.program_status_word = cur_psw;
        end
      end
      trap_ret_pkg::ST_PUSH_PSW: begin
        wr_en = 1'b1;
        wr_data = s_q.program_status_word;
        wr_data[trap_ret_pkg::MIE_BIT] = s_q.mie;
        s_d.mie = 1'b0;
        s_d.st = trap_ret_pkg::ST_PUSH_PCH;
      end
      trap_ret_pkg::ST_PUSH_PCH: begin
        wr_en = 1'b1;
        wr_addr = stk(s_q.sp - 16'h0001);
        wr_data = s_q.ret_pc[15:8];
        s_d.st = trap_ret_pkg::ST_PUSH_PCL;
      end
      trap_ret_pkg::ST_PUSH_PCL: begin
        wr_en = 1'b1;
        wr_addr = stk(s_q.sp - 16'h0002);
        wr_data = s_q.ret_pc[7:0];
        s_d.sp = s_q.sp - trap_ret_pkg::FRAME_BYTES;
        s_d.pc = s_q.vector;
        s_d.pc_load = 1'b1;
        s_d.busy = 1'b0;
        s_d.st = trap_ret_pkg::ST_IDLE;
      end
      trap_ret_pkg::ST_POP_A: begin
        rd_addr = stk(s_q.sp + 16'h0001);
        s_d.st = trap_ret_pkg::ST_POP_B;
      end
      trap_ret_pkg::ST_POP_B: begin
        rd_addr = stk(s_q.sp + 16'h0002);
        s_d.pcl = rd_data;
        s_d.st = trap_ret_pkg::ST_POP_C;
      end
      trap_ret_pkg::ST_POP_C: begin
        rd_addr = stk(s_q.sp + 16'h0003);
        s_d.pc = {rd_data, s_q.pcl};
        s_d.st = trap_ret_pkg::ST_POP_D;
      end
      trap_ret_pkg::ST_POP_D: begin
        s_d.program_status_word = rd_data;
        s_d.mie = rd_data[trap_ret_pkg::MIE_BIT];
        s_d.sp = s_q.sp + trap_ret_pkg::FRAME_BYTES;
        s_d.pc_load = 1'b1;
        // Final cycle of the return: a waiting request re-enters, if the restored enable is set, before any main-line opcode runs
        if (int_req && rd_data[trap_ret_pkg::MIE_BIT]) begin
          s_d.ret_pc = s_q.pc;
          s_d.vector = int_vector;
          s_d.pc_load = 1'b0;
          s_d.st = trap_ret_pkg::ST_PUSH_PSW;
        end else begin
          s_d.busy = 1'b0;
          s_d.st = trap_ret_pkg::ST_IDLE;
        end
      end
      default: begin
        s_d.busy = 1'b0;
        s_d.st = trap_ret_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_q <= '{st: trap_ret_pkg::ST_IDLE, sp: trap_ret_pkg::SP_RESET, pc: trap_ret_pkg::PC_RESET,
               ret_pc: trap_ret_pkg::PC_RESET, vector: trap_ret_pkg::PC_RESET,
               program_status_word: trap_ret_pkg::PSW_RESET, pcl: 8'h00, mie: 1'b0, pc_load: 1'b0,
               op_valid: 1'b0, op_byte: 8'h00, trap_reset: 1'b0, addr_error: 1'b0,
               soft_int: 1'b0, busy: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign op_valid_q = s_q.op_valid;
  assign op_byte_q = s_q.op_byte;
  assign pc_load_q = s_q.pc_load;
  assign pc_q = s_q.pc;
  assign sp_q = s_q.sp;
  assign psw_q = s_q.program_status_word;
  assign master_int_enable_q = s_q.mie;
  assign busy_q = s_q.busy;
  assign soft_interrupt_q = s_q.soft_int;
  assign addr_error_q = s_q.addr_error;
  assign addr_trap_reset_q = s_q.trap_reset;

endmodule
`default_nettype wire

// *** testbench/trap_ret_unit_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
module trap_ret_unit_monitor (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Inputs
  input wire trap_ret_pkg::fetch_t fetch,
  input wire logic instr_last,
  input wire logic int_req,
  input wire logic [15:0] int_vector,
  // Outputs
  input wire logic op_valid_q,
  input wire logic [7:0] op_byte_q,
  input wire logic pc_load_q,
  input wire logic [15:0] pc_q,
  input wire logic [15:0] sp_q,
  input wire logic [7:0] psw_q,
  input wire logic master_int_enable_q,
  input wire logic busy_q,
  input wire logic soft_interrupt_q,
  input wire logic addr_error_q,
  input wire logic addr_trap_reset_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic take, is_ret;
  assign take = fetch.valid && !busy_q;
  assign is_ret = op_valid_q && (op_byte_q == trap_ret_pkg::OP_RET_MASKABLE ||
                                 op_byte_q == trap_ret_pkg::OP_RET_NONMASKABLE);
  property p_trap; take && fetch.addr <= trap_ret_pkg::RAM_HI |=> addr_trap_reset_q && !op_valid_q; endproperty
  a_trap: assert property (p_trap) else $error("ram fetch not trapped");
  property p_nomem; take && fetch.addr > trap_ret_pkg::RAM_HI && fetch.addr < trap_ret_pkg::ROM_LO
    |=> op_valid_q && op_byte_q == trap_ret_pkg::NO_MEMORY_BYTE; endproperty
  a_nomem: assert property (p_nomem) else $error("unmapped fetch byte wrong");
  property p_ff; op_valid_q && op_byte_q == trap_ret_pkg::OP_SOFT_TRAP |-> soft_interrupt_q && addr_error_q;
  endproperty
  a_ff: assert property (p_ff) else $error("opcode FF not a soft trap");
  property p_vec; soft_interrupt_q |-> ##3 pc_load_q && pc_q == trap_ret_pkg::SOFT_TRAP_VECTOR; endproperty
  a_vec: assert property (p_vec) else $error("soft trap vector wrong");
  property p_push; soft_interrupt_q |=> !master_int_enable_q ##2 sp_q == $past(sp_q, 3) - 16'h0003; endproperty
  a_push: assert property (p_push) else $error("push frame wrong");
  property p_pop; is_ret |-> ##4 busy_q || (pc_load_q && sp_q == $past(sp_q, 4) + 16'h0003); endproperty
  a_pop: assert property (p_pop) else $error("pop frame wrong");
  property p_mie; is_ret |-> ##4 !pc_load_q || master_int_enable_q == psw_q[trap_ret_pkg::MIE_BIT]; endproperty
  a_mie: assert property (p_mie) else $error("master enable not restored");
  property p_reent; is_ret ##4 busy_q |-> ##3 pc_load_q && !master_int_enable_q; endproperty
  a_reent: assert property (p_reent) else $error("re-entry failed");
  // Main-line requests are accepted only by an idle sequencer; mid-push the enable is still high for one cycle
  property p_acc; !busy_q && !fetch.valid && instr_last && int_req && master_int_enable_q
    |=> busy_q ##3 pc_load_q && pc_q == $past(int_vector, 4); endproperty
  a_acc: assert property (p_acc) else $error("interrupt not accepted");
endmodule
bind trap_ret_unit trap_ret_unit_monitor trap_ret_unit_monitor_i (.mclk(mclk), .rst_n(rst_n), .fetch(fetch),
  .instr_last(instr_last), .int_req(int_req), .int_vector(int_vector), .op_valid_q(op_valid_q),
  .op_byte_q(op_byte_q), .pc_load_q(pc_load_q), .pc_q(pc_q), .sp_q(sp_q), .psw_q(psw_q),
  .master_int_enable_q(master_int_enable_q), .busy_q(busy_q), .soft_interrupt_q(soft_interrupt_q),
  .addr_error_q(addr_error_q), .addr_trap_reset_q(addr_trap_reset_q));
`default_nettype wire

// *** testbench/tb_trap_ret_unit.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_trap_ret_unit;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  trap_ret_pkg::fetch_t fetch = '0;
  logic [15:0] cur_pc = 16'h0000, int_vector = 16'h0000, pc_q, sp_q;
  logic [7:0] cur_psw = 8'h00, op_byte_q, psw_q;
  logic instr_last = 1'b0, mie_set = 1'b0, mie_clr = 1'b0, int_req = 1'b0, mie_m = 1'b0;
  logic op_valid_q, pc_load_q, master_int_enable_q, busy_q, soft_interrupt_q, addr_error_q, addr_trap_reset_q;
  logic [31:0] seed = 32'hE022;
  logic [8:0] exp_op[$];
  // Redirect note: new pc, stack pointer, status byte, master enable
  logic [40:0] exp_pc[$];
  // Stacked frame: return pc, status byte with the enable in it
  logic [23:0] stk[$];
  logic [15:0] sp_m = trap_ret_pkg::SP_RESET;
  int err_total = 0, check_count = 0;
  always #50 mclk = ~mclk;
  trap_ret_unit trap_ret_unit_i (.mclk(mclk), .rst_n(rst_n), .fetch(fetch), .cur_pc(cur_pc), .cur_psw(cur_psw),
    .instr_last(instr_last), .mie_set(mie_set), .mie_clr(mie_clr), .int_req(int_req), .int_vector(int_vector),
    .op_valid_q(op_valid_q), .op_byte_q(op_byte_q), .pc_load_q(pc_load_q), .pc_q(pc_q), .sp_q(sp_q),
    .psw_q(psw_q), .master_int_enable_q(master_int_enable_q), .busy_q(busy_q),
    .soft_interrupt_q(soft_interrupt_q), .addr_error_q(addr_error_q), .addr_trap_reset_q(addr_trap_reset_q));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic cmp(input string nm, input logic [40:0] e, input logic [40:0] s);
    check_count++;
    if (e !== s) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cmp_op();
    cmp("op", exp_op.size() ? exp_op.pop_front() : 9'h1FF, {addr_trap_reset_q, op_valid_q ? op_byte_q : 8'h00});
  endtask
  task automatic cmp_pc();
    cmp("pc sp psw mie", exp_pc.size() ? exp_pc.pop_front() : '1, {pc_q, sp_q, psw_q, master_int_enable_q});
  endtask
  always @(negedge mclk) begin
    if (rst_n && (op_valid_q === 1'b1 || addr_trap_reset_q === 1'b1)) cmp_op();
    if (rst_n && pc_load_q === 1'b1) cmp_pc();
  end
  task automatic push_frame(input logic [15:0] p, input logic [15:0] vec, input logic [7:0] ps);
    logic [7:0] sb;
    sb = ps;
    sb[trap_ret_pkg::MIE_BIT] = mie_m;
    stk.push_back({p, sb});
    sp_m -= 16'h0003;
    mie_m = 1'b0;
    exp_pc.push_back({vec, sp_m, ps, 1'b0});
  endtask
  task automatic pop_frame();
    logic [23:0] f;
    f = stk.pop_back();
    sp_m += 16'h0003;
    mie_m = f[trap_ret_pkg::MIE_BIT];
    if (int_req && mie_m) push_frame(f[23:8], int_vector, f[7:0]);
    else exp_pc.push_back({f[23:8], sp_m, f[7:0], mie_m});
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (busy_q !== 1'b0 && n < 50);
    if (n == 50) cmp("busy", 41'h0, {40'h0, busy_q});
  endtask
  // Callers sit at a falling edge
  task automatic do_fetch(input logic [15:0] a, input logic [7:0] b);
    logic [7:0] v;
    v = (a >= trap_ret_pkg::ROM_LO) ? b : trap_ret_pkg::NO_MEMORY_BYTE;
    cur_pc = seed[15:0];
    cur_psw = seed[23:16];
    seed = xs(seed);
    if (a <= trap_ret_pkg::RAM_HI) exp_op.push_back(9'h100);
    else begin
      exp_op.push_back({1'b0, v});
      if (v == trap_ret_pkg::OP_SOFT_TRAP) push_frame(cur_pc, trap_ret_pkg::SOFT_TRAP_VECTOR, cur_psw);
      if (v == trap_ret_pkg::OP_RET_MASKABLE || v == trap_ret_pkg::OP_RET_NONMASKABLE) pop_frame();
    end
    fetch = '{1'b1, a, b};
    @(negedge mclk);
    fetch.valid = 1'b0;
    wait_idle();
  endtask
  task automatic results();
    if (exp_op.size() + exp_pc.size() != 0) cmp("leftover", 41'h0, 41'(exp_op.size() + exp_pc.size()));
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #2000000;
    err_total++;
    results();
  end
  initial begin
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    for (int i = 0; i < 4; i++) do_fetch({3'b111, seed[28:16]}, {2'b01, seed[5:0]});
    $display("test rom fetch done");
    stk.delete();
    for (int i = 0; i < 4; i++) do_fetch(i[1] ? {7'h0, i[0], 8'h3F} : {10'h0, i[0], 5'h0}, 8'h12);
    $display("test trap area done");
    do_fetch(16'h0140, 8'h12);
    do_fetch(16'hE100, trap_ret_pkg::OP_RET_MASKABLE);
    do_fetch(16'hFFFF, trap_ret_pkg::OP_SOFT_TRAP);
    do_fetch(16'hE101, trap_ret_pkg::OP_RET_NONMASKABLE);
    $display("test soft trap done");
    mie_set = 1'b1;
    @(negedge mclk);
    mie_set = 1'b0;
    mie_m = 1'b1;
    int_vector = {seed[15:1], 1'b0};
    cur_pc = seed[31:16];
    seed = xs(seed);
    instr_last = 1'b1;
    int_req = 1'b1;
    push_frame(cur_pc, int_vector, cur_psw);
    @(negedge mclk);
    instr_last = 1'b0;
    wait_idle();
    do_fetch(16'hE102, trap_ret_pkg::OP_RET_NONMASKABLE);
    int_req = 1'b0;
    do_fetch(16'hE103, trap_ret_pkg::OP_RET_MASKABLE);
    $display("test re-entry done");
    int_req = 1'b1;
    instr_last = 1'b1;
    do_fetch(16'hDFFF, 8'h00);
    int_req = 1'b0;
    instr_last = 1'b0;
    do_fetch(16'hE104, trap_ret_pkg::OP_RET_MASKABLE);
    $display("test priority done");
    // Clear beats set; a pending request must then stay unanswered
    mie_set = 1'b1;
    mie_clr = 1'b1;
    @(negedge mclk);
    mie_set = 1'b0;
    mie_clr = 1'b0;
    mie_m = 1'b0;
    int_req = 1'b1;
    instr_last = 1'b1;
    repeat (4) @(negedge mclk);
    cmp("mie", {40'h0, mie_m}, {40'h0, master_int_enable_q});
    cmp("busy", 41'h0, {40'h0, busy_q});
    int_req = 1'b0;
    instr_last = 1'b0;
    $display("test enable clear done");
    repeat (4) @(negedge mclk);
    results();
  end
endmodule
`default_nettype wire
